//--- verilog/pclb_regs.sv
`timescale 1ns/1ns
// Current-limit behaviour register bank with identification registers.

module pclb_regs
    import pclb_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Register access port from the serial interface.
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    // Device context.
    input wire logic i_sleep,
    input wire logic i_auto_discharge_enable,
    input wire logic i_port1_switch_enable,
    input wire logic i_port2_switch_enable,
    input wire logic i_port1_timed_discharge_request,
    input wire logic i_port2_timed_discharge_request,
    input wire logic i_timer_done,
    input wire logic i_other_alert1,
    input wire logic i_other_alert2,
    input wire logic i_ration_hit1,
    input wire logic i_ration_hit2,
    // Port 1 controls.
    output logic [11:0] o_port1_vmin_mv,
    output logic [11:0] o_port1_imin_ma,
    output logic o_port1_imin_valid,
    output logic o_port1_discharge_load,
    output logic o_port1_load_parallel,
    // Port 2 controls.
    output logic [11:0] o_port2_vmin_mv,
    output logic [11:0] o_port2_imin_ma,
    output logic o_port2_imin_valid,
    output logic o_port2_discharge_load,
    output logic o_port2_load_parallel,
    // Ration status and alerts.
    output logic o_charge_clear1,
    output logic o_charge_clear2,
    output logic o_ration1,
    output logic o_ration2,
    output logic o_alert1_n,
    output logic o_alert2_n
);
    import pclb_pkg::*;

    logic [7:0] p1_q, p1_d, p2_q, p2_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic rat1_q, rat1_d, rat2_q, rat2_d;
    logic clr1_q, clr1_d, clr2_q, clr2_d;
    logic tdis1_q, tdis1_d, tdis2_q, tdis2_d;
    logic sync1_q, sync2_q;
    logic man1, man2;

    // Sleep level from the power manager is synchronised.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= i_sleep;
            sync2_q <= sync1_q;
        end
    end

    // Writable register next values and read data.
    always_comb begin
        p1_d = p1_q;
        p2_d = p2_q;
        rdata_d = rdata_q;
        rvalid_d = i_rd;
        clr1_d = 1'b0;
        clr2_d = 1'b0;
        if (sync2_q) begin
            p1_d = PCLB_LIMIT_RST;
            p2_d = PCLB_LIMIT_RST;
        end else if (i_wr) begin
            // Identification addresses fall through untouched.
            case (i_addr)
                PCLB_OFS_PORT2: p2_d = i_wdata;
                PCLB_OFS_PORT1: p1_d = i_wdata;
                PCLB_OFS_RATION: begin
                    clr1_d = i_wdata[PCLB_RCLR1_BIT];
                    clr2_d = i_wdata[PCLB_RCLR2_BIT];
                end
                default: begin
                end
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                PCLB_OFS_PORT2: rdata_d = p2_q;
                PCLB_OFS_PORT1: rdata_d = p1_q;
                PCLB_OFS_PART: rdata_d = PCLB_PART_CODE;
                PCLB_OFS_MAKER: rdata_d = PCLB_MAKER_CODE;
                PCLB_OFS_STEP: rdata_d = PCLB_STEP_CODE;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // Ration status: clear wins only when no new hit arrives.
    always_comb begin
        rat1_d = i_ration_hit1 | (rat1_q & ~clr1_d);
        rat2_d = i_ration_hit2 | (rat2_q & ~clr2_d);
    end

    // Internally timed discharge: held from request until timer finishes.
    always_comb begin
        tdis1_d = i_port1_timed_discharge_request
            | (tdis1_q & ~i_timer_done);
        tdis2_d = i_port2_timed_discharge_request
            | (tdis2_q & ~i_timer_done);
    end

    // State registers.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            p1_q <= PCLB_LIMIT_RST;
            p2_q <= PCLB_LIMIT_RST;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
            rat1_q <= 1'b0;
            rat2_q <= 1'b0;
            clr1_q <= 1'b0;
            clr2_q <= 1'b0;
            tdis1_q <= 1'b0;
            tdis2_q <= 1'b0;
        end else begin
            p1_q <= p1_d;
            p2_q <= p2_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            rat1_q <= rat1_d;
            rat2_q <= rat2_d;
            clr1_q <= clr1_d;
            clr2_q <= clr2_d;
            tdis1_q <= tdis1_d;
            tdis2_q <= tdis2_d;
        end
    end

    // Per-port field decoders.
    pclb_port_decode u_port1 (
        .i_reg(p1_q),
        .i_auto_dis(i_auto_discharge_enable),
        .i_switch_en(i_port1_switch_enable),
        .o_vmin_mv(o_port1_vmin_mv),
        .o_imin_ma(o_port1_imin_ma),
        .o_imin_valid(o_port1_imin_valid),
        .o_dload_on(man1),
        .o_dload_parallel(o_port1_load_parallel)
    );
    pclb_port_decode u_port2 (
        .i_reg(p2_q),
        .i_auto_dis(i_auto_discharge_enable),
        .i_switch_en(i_port2_switch_enable),
        .o_vmin_mv(o_port2_vmin_mv),
        .o_imin_ma(o_port2_imin_ma),
        .o_imin_valid(o_port2_imin_valid),
        .o_dload_on(man2),
        .o_dload_parallel(o_port2_load_parallel)
    );

    // Output drive; load on from manual or timed discharge.
    assign o_port1_discharge_load = man1 | tdis1_q;
    assign o_port2_discharge_load = man2 | tdis2_q;
    assign o_rdata = rdata_q;
    assign o_rvalid = rvalid_q;
    assign o_charge_clear1 = clr1_q;
    assign o_charge_clear2 = clr2_q;
    assign o_ration1 = rat1_q;
    assign o_ration2 = rat2_q;
    // Alert released only when no other indicator is active.
    assign o_alert1_n = ~(rat1_q | i_other_alert1);
    assign o_alert2_n = ~(rat2_q | i_other_alert2);
endmodule : pclb_regs

//--- pkg/pclb_pkg.sv
// Package with register map, field layout and reset values of the bank.
package pclb_pkg;
    // Register offsets.
    localparam logic [7:0] PCLB_OFS_PORT2 = 8'h23;
    localparam logic [7:0] PCLB_OFS_PORT1 = 8'h24;
    localparam logic [7:0] PCLB_OFS_PART = 8'hFD;
    localparam logic [7:0] PCLB_OFS_MAKER = 8'hFE;
    localparam logic [7:0] PCLB_OFS_STEP = 8'hFF;
    localparam logic [7:0] PCLB_OFS_RATION = 8'h22;
    // Field positions within a limit behaviour register.
    localparam int PCLB_VMIN_LSB = 6;
    localparam int PCLB_DLOAD_BIT = 5;
    localparam int PCLB_IMIN_LSB = 2;
    localparam int PCLB_RSV_LSB = 0;
    // Field positions within the ration configuration register.
    localparam int PCLB_RCLR1_BIT = 6;
    localparam int PCLB_RCLR2_BIT = 2;
    // Reset value of each limit behaviour register.
    localparam logic [7:0] PCLB_LIMIT_RST = 8'h96;
    // Identification values; arbitrary neutral values.
    localparam logic [7:0] PCLB_PART_CODE = 8'h5A;
    localparam logic [7:0] PCLB_MAKER_CODE = 8'hA5;
    localparam logic [7:0] PCLB_STEP_CODE = 8'h01;
    // Bus threshold in millivolts per select code.
    localparam logic [11:0] PCLB_VMIN_MV0 = 12'h5DC;
    localparam logic [11:0] PCLB_VMIN_MV1 = 12'h6D6;
    localparam logic [11:0] PCLB_VMIN_MV2 = 12'h7D0;
    localparam logic [11:0] PCLB_VMIN_MV3 = 12'h8CA;
    // Floor current in milliamps per select code.
    localparam logic [11:0] PCLB_IMIN_MA0 = 12'h064;
    localparam logic [11:0] PCLB_IMIN_MA1 = 12'h212;
    localparam logic [11:0] PCLB_IMIN_MA2 = 12'h3C0;
    localparam logic [11:0] PCLB_IMIN_MA3 = 12'h500;
    localparam logic [11:0] PCLB_IMIN_MA4 = 12'h640;
    localparam logic [11:0] PCLB_IMIN_MA5 = 12'h852;
endpackage : pclb_pkg

//--- verilog/pclb_port_decode.sv
`timescale 1ns/1ns
// Decoder that turns one port's limit register into its controls.
module pclb_port_decode
    import pclb_pkg::*;
(
    // Register contents and context.
    input wire logic [7:0] i_reg,
    input wire logic i_auto_dis,
    input wire logic i_switch_en,
    // Decoded controls.
    output logic [11:0] o_vmin_mv,
    output logic [11:0] o_imin_ma,
    output logic o_imin_valid,
    output logic o_dload_on,
    output logic o_dload_parallel
);
    logic [1:0] vsel;
    logic [2:0] isel;

    // Field extraction.
    assign vsel = i_reg[PCLB_VMIN_LSB +: 2];
    assign isel = i_reg[PCLB_IMIN_LSB +: 3];

    // Threshold and floor current tables.
    always_comb begin
        case (vsel)
            2'h0: o_vmin_mv = PCLB_VMIN_MV0;
            2'h1: o_vmin_mv = PCLB_VMIN_MV1;
            2'h2: o_vmin_mv = PCLB_VMIN_MV2;
            default: o_vmin_mv = PCLB_VMIN_MV3;
        endcase
        o_imin_valid = 1'b1;
        case (isel)
            3'h0: o_imin_ma = PCLB_IMIN_MA0;
            3'h1: o_imin_ma = PCLB_IMIN_MA1;
            3'h2: o_imin_ma = PCLB_IMIN_MA2;
            3'h3: o_imin_ma = PCLB_IMIN_MA3;
            3'h4: o_imin_ma = PCLB_IMIN_MA4;
            3'h5: o_imin_ma = PCLB_IMIN_MA5;
            default: begin
                o_imin_ma = 12'h000;
                o_imin_valid = 1'b0;
            end
        endcase
    end

    // Host-timed load holds while the bit is set, unless auto mode rules.
    assign o_dload_on = i_reg[PCLB_DLOAD_BIT] & ~i_auto_dis;
    assign o_dload_parallel = o_dload_on & i_switch_en;
endmodule : pclb_port_decode

//--- verification/pclb_regs_sva.sv
// Checker of the limit behaviour register bank ports.
`timescale 1ns/1ns
module pclb_regs_chk
    import pclb_pkg::*;
(
    // Watched ports.
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic i_sleep,
    input wire logic i_port1_switch_enable,
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic [11:0] o_port1_vmin_mv,
    input wire logic [11:0] o_port2_vmin_mv,
    input wire logic [11:0] o_port1_imin_ma,
    input wire logic o_port1_imin_valid,
    input wire logic o_port1_discharge_load,
    input wire logic o_port1_load_parallel
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Read answers, identification codes and decoded controls.
    a_read_answer_pulse: assert property (o_rvalid == $past(i_rd))
        else $error("read answer pulse misplaced");
    a_part_code_read: assert property (i_rd && i_addr == 8'hFD
        |=> o_rdata == PCLB_PART_CODE) else $error("part code wrong");
    a_maker_code_read: assert property (i_rd && i_addr == 8'hFE
        |=> o_rdata == PCLB_MAKER_CODE) else $error("maker code wrong");
    a_step_code_read: assert property (i_rd && i_addr == 8'hFF
        |=> o_rdata == PCLB_STEP_CODE) else $error("step code wrong");
    a_sleep_reload_regs: assert property (i_sleep [*5] |->
        o_port1_vmin_mv == PCLB_VMIN_MV2 && o_port2_vmin_mv == PCLB_VMIN_MV2 &&
        o_port1_imin_ma == PCLB_IMIN_MA5 && o_port1_imin_valid)
        else $error("sleep kept register contents");
    a_vmin_code_legal: assert property (o_port1_vmin_mv inside
        {12'h5DC, 12'h6D6, 12'h7D0, 12'h8CA}) else $error("bad threshold");
    a_imin_undefined_zero: assert property (!o_port1_imin_valid
        |-> o_port1_imin_ma == 12'h000) else $error("undefined floor code");
    a_parallel_needs_switch: assert property (o_port1_load_parallel
        |-> i_port1_switch_enable && o_port1_discharge_load)
        else $error("parallel load without switch or load");
endmodule : pclb_regs_chk
bind pclb_regs pclb_regs_chk i_chk (.*);

//--- verification/pclb_host.sv
// Host model that issues single-cycle register accesses.
`timescale 1ns/1ns
module pclb_host (
    // Clock and read return.
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    // Access strobes.
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    initial {o_wr, o_rd, o_addr, o_wdata} = 18'h00000;
    // Write strobe; callers keep the two low bits of the limit registers as read back.
    task automatic wr(input logic [7:0] a, d);
        @(negedge i_clk);
        {o_wr, o_addr, o_wdata} = {1'b1, a, d};
        @(negedge i_clk);
        {o_wr, o_addr, o_wdata} = {1'b0, ~a, ~d};
    endtask : wr
    // Read strobe; the answer is taken while its pulse stands.
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
        output bit ok);
        @(negedge i_clk);
        {o_rd, o_addr} = {1'b1, a};
        @(negedge i_clk);
        {o_rd, o_addr} = {1'b0, ~a};
        ok = (i_rvalid === 1'b1);
        d = i_rdata;
    endtask : rd
endmodule : pclb_host

//--- verification/pclb_regs_bench.sv
// Self-checking bench for the limit behaviour register bank.
`timescale 1ns/1ns
module pclb_regs_bench;
    import pclb_pkg::*;
    logic i_clk = 0, i_rst = 1, i_wr, i_rd, o_rvalid, i_sleep = 0;
    logic i_auto_discharge_enable = 0, i_port1_switch_enable = 0;
    logic i_port2_switch_enable = 0, i_port1_timed_discharge_request = 0;
    logic i_port2_timed_discharge_request = 0, i_timer_done = 0;
    logic i_other_alert1 = 0, i_other_alert2 = 0, i_ration_hit1 = 0;
    logic i_ration_hit2 = 0, o_port1_imin_valid, o_port2_imin_valid;
    logic o_port1_discharge_load, o_port1_load_parallel, o_charge_clear1;
    logic o_port2_discharge_load, o_port2_load_parallel, o_charge_clear2;
    logic o_ration1, o_ration2, o_alert1_n, o_alert2_n;
    logic [7:0] i_addr, i_wdata, o_rdata, rd_v, v;
    logic [11:0] o_port1_vmin_mv, o_port2_vmin_mv;
    logic [11:0] o_port1_imin_ma, o_port2_imin_ma;
    logic [7:0] ids [3] = '{PCLB_PART_CODE, PCLB_MAKER_CODE, PCLB_STEP_CODE};
    int imin_tab [8] = '{100, 530, 960, 1280, 1600, 2130, 0, 0};
    int n_errors = 0, n_compared = 0;
    pclb_regs i_dut (.*);
    pclb_host i_host (.i_clk, .i_rdata(o_rdata), .i_rvalid(o_rvalid),
        .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
    // Clock of 40 ns period.
    always #20 i_clk = ~i_clk;
    // Compares a seen value with the expected one.
    task automatic chk(input logic [11:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Reads one register and compares the answer.
    task automatic rchk(input logic [7:0] a, exp);
        bit ok;
        i_host.rd(a, rd_v, ok);
        chk({11'h000, ok}, 12'h001);
        chk({4'h0, rd_v}, {4'h0, exp});
    endtask : rchk
    // Prints the verdict and ends the run.
    task automatic summarize();
        if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize
    // Watchdog that ends a hung run as a failure.
    initial begin
        #1000000;
        n_errors++;
        summarize();
    end
    // Main sequence of accesses and checks.
    initial begin
        repeat (12) @(negedge i_clk);
        i_rst = 0;
        rchk(PCLB_OFS_PORT2, PCLB_LIMIT_RST);
        rchk(PCLB_OFS_PORT1, PCLB_LIMIT_RST);
        for (int i = 0; i < 3; i++) begin
            i_host.wr(8'hFD + 8'(i), 8'h00);
            rchk(8'hFD + 8'(i), ids[i]);
        end
        rchk(8'h30, 8'h00);
        for (int i = 0; i < 8; i++) begin
            v = {i[1:0], 1'b0, i[2:0], 2'b10};
            i_host.wr(PCLB_OFS_PORT1, v);
            i_host.wr(PCLB_OFS_PORT2, v);
            rchk(PCLB_OFS_PORT2, v);
            rchk(PCLB_OFS_PORT1, v);
            chk(o_port1_vmin_mv, 12'(1500 + 250 * i[1:0]));
            chk(o_port2_vmin_mv, 12'(1500 + 250 * i[1:0]));
            chk(o_port1_imin_ma, 12'(imin_tab[i]));
            chk(o_port2_imin_ma, 12'(imin_tab[i]));
            chk({11'h000, o_port2_imin_valid}, 12'(i < 6));
            chk({11'h000, o_port1_imin_valid}, 12'(i < 6));
        end
        i_host.wr(PCLB_OFS_PORT1, 8'hBE);
        repeat (20) @(negedge i_clk);
        chk({11'h000, o_port1_discharge_load}, 12'h001);
        chk({11'h000, o_port1_load_parallel}, 12'h000);
        i_port1_switch_enable = 1;
        @(negedge i_clk);
        chk({11'h000, o_port1_load_parallel}, 12'h001);
        i_auto_discharge_enable = 1;
        @(negedge i_clk);
        chk({11'h000, o_port1_discharge_load}, 12'h000);
        chk({11'h000, o_port1_load_parallel}, 12'h000);
        i_auto_discharge_enable = 0;
        i_port1_switch_enable = 0;
        i_host.wr(PCLB_OFS_PORT1, PCLB_LIMIT_RST);
        chk({11'h000, o_port1_discharge_load}, 12'h000);
        i_port2_switch_enable = 1;
        i_host.wr(PCLB_OFS_PORT2, 8'hB6);
        chk({11'h000, o_port2_discharge_load}, 12'h001);
        chk({11'h000, o_port2_load_parallel}, 12'h001);
        i_host.wr(PCLB_OFS_PORT2, PCLB_LIMIT_RST);
        i_port2_switch_enable = 0;
        chk({11'h000, o_port2_discharge_load}, 12'h000);
        i_port2_timed_discharge_request = 1;
        @(negedge i_clk);
        i_port2_timed_discharge_request = 0;
        repeat (5) @(negedge i_clk);
        chk({11'h000, o_port2_discharge_load}, 12'h001);
        chk({11'h000, o_port1_discharge_load}, 12'h000);
        i_timer_done = 1;
        @(negedge i_clk);
        i_timer_done = 0;
        @(negedge i_clk);
        chk({11'h000, o_port2_discharge_load}, 12'h000);
        i_ration_hit1 = 1;
        @(negedge i_clk);
        i_ration_hit1 = 0;
        @(negedge i_clk);
        chk({11'h000, o_ration1}, 12'h001);
        chk({11'h000, o_alert1_n}, 12'h000);
        i_host.wr(PCLB_OFS_RATION, 8'h40);
        chk({11'h000, o_charge_clear1}, 12'h001);
        chk({11'h000, o_charge_clear2}, 12'h000);
        @(negedge i_clk);
        chk({11'h000, o_charge_clear1}, 12'h000);
        chk({11'h000, o_ration1}, 12'h000);
        chk({11'h000, o_alert1_n}, 12'h001);
        i_other_alert2 = 1;
        i_ration_hit2 = 1;
        @(negedge i_clk);
        i_ration_hit2 = 0;
        chk({11'h000, o_ration2}, 12'h001);
        i_host.wr(PCLB_OFS_RATION, 8'h04);
        chk({11'h000, o_charge_clear2}, 12'h001);
        chk({11'h000, o_ration2}, 12'h000);
        chk({11'h000, o_alert2_n}, 12'h000);
        i_other_alert2 = 0;
        @(negedge i_clk);
        chk({11'h000, o_alert2_n}, 12'h001);
        i_host.wr(PCLB_OFS_PORT1, 8'h42);
        i_host.wr(PCLB_OFS_PORT2, 8'h42);
        rchk(PCLB_OFS_PORT1, 8'h42);
        i_sleep = 1;
        repeat (4) @(negedge i_clk);
        i_host.wr(PCLB_OFS_PORT1, 8'h42);
        rchk(PCLB_OFS_PORT1, PCLB_LIMIT_RST);
        rchk(PCLB_OFS_PORT2, PCLB_LIMIT_RST);
        i_sleep = 0;
        summarize();
    end
endmodule : pclb_regs_bench
